// File: core/dpr_pkg.sv
/*
 Shared constants and carriers for the dual-port RAM access control.
 Assumes one system clock; all inputs are synchronous to it.
*/
package dpr_pkg;
   // Storage geometry
   localparam int ADDR_W   = 16;
   localparam int DATA_W   = 8;
   localparam int WORD_W   = DATA_W + 1;
   // Bit position of the parity bit inside a stored word
   localparam int PAR_POS  = 8;
   // Reset values
   localparam logic RST_BIT = 1'b0;
   localparam logic [ADDR_W-1:0] RST_ADDR = 16'h0000;
   localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
   // Arbiter phase: host samples on phase 0, processor on phase 1
   localparam logic PH_HOST = 1'b0;
   localparam logic PH_PROC = 1'b1;

   // Host side command group
   typedef struct packed {
      logic [ADDR_W-1:0] addr;     // Byte address, bit 0 = host_addr_bit0
      logic              bhen;     // Byte-high-enable
      logic              rdCmd;    // Memory read command
      logic              wrCmd;    // Memory write command
      logic              memAen;   // host_mem_addr_enable
      logic              busLock;  // System bus lock
   } dpr_host_t;

   // Local processor command group
   typedef struct packed {
      logic [ADDR_W-1:0] addr;     // Local address
      logic              lockBit;  // proc_lock_addr_bit
      logic              rd;       // Read cycle
      logic              wr;       // Write cycle
      logic              cmd;      // Cycle command strobe
   } dpr_proc_t;
endpackage : dpr_pkg

// File: core/dpr_parity_ram.sv
/*
 Byte-wide storage with one parity bit per location.
 Assumes write strobes come one per cycle from the access controller.
*/
`timescale 1ns/1ps
`default_nettype none
module dpr_parity_ram #(
   parameter int ADDR_W = dpr_pkg::ADDR_W
) (
   input  wire logic                      mclk,      // System clock
   input  wire logic [ADDR_W-1:0]         addr,      // Muxed RAM address
   input  wire logic                      wrEn,      // Write this cycle
   input  wire logic [dpr_pkg::DATA_W-1:0] wrData,   // Byte to store
   output logic      [dpr_pkg::DATA_W-1:0] rdData,   // Stored byte
   output logic                            parMiss   // Stored vs new parity
);
   // Nine bits per location, sharing address and control
   logic [dpr_pkg::WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [dpr_pkg::WORD_W-1:0] rdWord_q;

   // Even parity: the bit makes the nine-bit word have even weight
   function automatic logic evenPar(input logic [dpr_pkg::DATA_W-1:0] b);
      evenPar = ^b;
   endfunction : evenPar

   // Write stores the byte with its freshly generated parity bit
   always_ff @(posedge mclk) begin
      if (wrEn) begin
         mem[addr] <= {evenPar(wrData), wrData};
      end
   end

   // Synchronous read keeps the array mappable onto block memory
   always_ff @(posedge mclk) begin
      rdWord_q <= mem[addr];
   end

   assign rdData  = rdWord_q[dpr_pkg::DATA_W-1:0];
   // Recomputed parity against the stored bit
   assign parMiss = rdWord_q[dpr_pkg::PAR_POS]
                    ^ evenPar(rdWord_q[dpr_pkg::DATA_W-1:0]);

   initial begin
      if (ADDR_W < 1 || ADDR_W > 20) begin
         $error("dpr_parity_ram: ADDR_W out of range");
      end
   end
endmodule : dpr_parity_ram
`default_nettype wire

// File: core/dpr_access_ctrl.sv
/*
 Arbiter and data-path control for a byte-wide dual-port RAM shared by a
 system-bus host and a local processor.
 Assumes an outside RAM controller that takes read/write start requests,
 answers with an active-low acknowledge and a cycle-done level, and
 signals column strobe; all inputs synchronous to mclk.
*/
// Behaviour
// - Decode byte lane from bhen and bit 0
// - First cycle byte select follows address bit 0
// - Done edge registers ack enable, acks if no hold
// - Done edge registers hold, forcing odd byte
// - Done ends grants; release when done falls
// - Host grant terminate conditions
// - Processor grant clear conditions
// - Word access: second cycle odd, then ack
// - Ack enable and host request clear terms
// - Host lockout set on permitted grant, held
// - RAM address from processor when it holds grant
// - Start strobes by grant; ack low completes
// - Processor buffer enable and direction
// - Host write buffer lane enables
// - Host read latch capture and output enable
// - Storage is 64K by eight plus parity
// - Even parity generated on every write
// - Read compares parity, registers error flag
// - Disable holds error clear; processor must enable
// - Host request from address enable and command
// - Arbiter halves sample on alternate phases
// - Processor lock taken from lock bit at start
// - Word access is two byte cycles, one ack
`timescale 1ns/1ps
`default_nettype none
module dpr_access_ctrl #(
   parameter int ADDR_W = dpr_pkg::ADDR_W
) (
   input  wire logic                 mclk,            // 125 MHz clock
   input  wire logic                 rst_n,           // Sync reset, low
   input  wire dpr_pkg::dpr_host_t   host,            // Host command group
   input  wire logic [15:0]          hostDataIn,      // Host write data
   output logic      [15:0]          hostDataOut,     // Host read latches
   output logic                      hostRdLatchOutEn, // Latch drive enable
   output logic                      hostWrBufLowEn,  // Low write lane
   output logic                      hostWrBufHighEn, // High write lane
   output logic                      hostMemAck,      // Host acknowledge
   input  wire dpr_pkg::dpr_proc_t   proc,            // Processor group
   input  wire logic                 procPermitLock,  // Host may lock RAM
   input  wire logic                 parityCheckDisable, // Hold error clear
   input  wire logic [7:0]           procDataIn,      // Processor write data
   output logic      [7:0]           procDataOut,     // Processor read data
   output logic                      procBufEn,       // Processor buffer en
   output logic                      procBufToProc,   // Direction to proc
   output logic                      procRamAck,      // Processor ready
   output logic                      procLockOut,     // Processor lock state
   output logic                      parityErrorFlag, // Parity error
   input  wire logic                 ramCycleDone,    // Controller done
   input  wire logic                 ramCtrlAck_n,    // Controller ack, low
   input  wire logic                 ramColStrobe,    // Column strobe active
   output logic                      ramReadStart,    // Start read
   output logic                      ramWriteStart,   // Start write
   output logic      [ADDR_W-1:0]    ramAddr          // Muxed RAM address
);
   // Arbiter and control state
   logic        phase_q;
   logic        hostReq_q, procReq_q;
   logic        hostGrant_q, procGrant_q;
   logic        hold_q, forceOdd_q;
   logic        lockout_q, procLock_q;
   logic        done_q, reqCond_q, procCmd_q, hostGrantPrev_q;
   logic        procGrantPrev_q;
   logic [7:0]  latchLo_q, latchHi_q;

   // Combinational terms
   logic        reqCond, doneRise;
   logic        hostGrantTerminate, procGrantClear;
   logic        hostAckEnable, hostRequestClear;
   logic        hostStart, procStart, ramByteSelect, ctrlAck;
   logic        memWrEn, parMiss;
   logic [7:0]  ramWrByte, ramRdByte;

   // Byte-lane decode: only bhen high with an even address is a word
   function automatic logic isWord(input logic bhen, input logic a0);
      isWord = bhen & ~a0;
   endfunction : isWord

   // Upper lane is used only for an odd byte with bhen high
   function automatic logic upperLane(input logic bhen, input logic sel);
      upperLane = bhen & sel;
   endfunction : upperLane

   assign reqCond  = host.memAen & (host.rdCmd | host.wrCmd);
   assign doneRise = ramCycleDone & ~done_q;
   assign ctrlAck  = ~ramCtrlAck_n;
   assign hostStart = hostGrant_q & ~hostGrantPrev_q;
   assign procStart = procGrant_q & ~procGrantPrev_q;

   // Both grant kills stay asserted for as long as done is high
   assign hostGrantTerminate = procGrant_q | procLock_q | ramCycleDone
                             | (~hostReq_q & ~hostGrant_q)
                             | ~rst_n;
   assign procGrantClear = ramCycleDone | hostGrant_q | lockout_q
                         | hold_q | ~rst_n;

   assign hostAckEnable    = hold_q | ~hostGrant_q;
   assign hostRequestClear = (ramCycleDone & ~hold_q & hostGrant_q)
                           | ~host.memAen;

   // Second byte cycle of a word is forced to the odd byte
   assign ramByteSelect = forceOdd_q | host.addr[0];

   // Write byte steering: processor, then the host lane in use
   always_comb begin
      if (procGrant_q) begin
         ramWrByte = procDataIn;
      end else if (upperLane(host.bhen, ramByteSelect)) begin
         ramWrByte = hostDataIn[15:8];
      end else begin
         ramWrByte = hostDataIn[7:0];
      end
   end

   // Array written once, when the controller acknowledges a write
   assign memWrEn = ctrlAck & ((hostGrant_q & host.wrCmd)
                             | (procGrant_q & proc.wr));

   dpr_parity_ram #(
      .ADDR_W (ADDR_W)
   ) u_ram (
      .mclk    (mclk),
      .addr    (ramAddr),
      .wrEn    (memWrEn),
      .wrData  (ramWrByte),
      .rdData  (ramRdByte),
      .parMiss (parMiss)
   );

   // Edge detectors for done, host request, commands and grants
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         done_q          <= dpr_pkg::RST_BIT;
         reqCond_q       <= dpr_pkg::RST_BIT;
         procCmd_q       <= dpr_pkg::RST_BIT;
         hostGrantPrev_q <= dpr_pkg::RST_BIT;
         procGrantPrev_q <= dpr_pkg::RST_BIT;
      end else begin
         done_q          <= ramCycleDone;
         reqCond_q       <= reqCond;
         procCmd_q       <= proc.cmd;
         hostGrantPrev_q <= hostGrant_q;
         procGrantPrev_q <= procGrant_q;
      end
   end

   // Alternate phases stand in for the two opposite clock edges
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         phase_q <= dpr_pkg::PH_HOST;
      end else begin
         phase_q <= ~phase_q;
      end
   end

   // Host request flag: set on a new command so a still-held command
   // after its acknowledge cannot start a duplicate cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hostReq_q <= dpr_pkg::RST_BIT;
      end else if (reqCond & ~reqCond_q) begin
         hostReq_q <= 1'b1;
      end else if (hostRequestClear) begin
         hostReq_q <= 1'b0;
      end
   end

   // Processor request: set by command, cleared by its acknowledge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         procReq_q <= dpr_pkg::RST_BIT;
      end else if (proc.cmd & ~procCmd_q) begin
         procReq_q <= 1'b1;
      end else if (procGrant_q & ctrlAck) begin
         procReq_q <= 1'b0;
      end
   end

   // Host arbiter half; held off while the processor owns the RAM
   always_ff @(posedge mclk) begin
      if (hostGrantTerminate) begin
         hostGrant_q <= dpr_pkg::RST_BIT;
      end else if (phase_q == dpr_pkg::PH_HOST) begin
         hostGrant_q <= hostReq_q & ~procGrant_q;
      end
   end

   // Processor arbiter half on the opposite phase
   always_ff @(posedge mclk) begin
      if (procGrantClear) begin
         procGrant_q <= dpr_pkg::RST_BIT;
      end else if (phase_q == dpr_pkg::PH_PROC) begin
         procGrant_q <= procReq_q & ~hostGrant_q;
      end
   end

   // Word hold: set at the first cycle start, cleared at the second
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hold_q <= dpr_pkg::RST_BIT;
      end else if (hostStart) begin
         hold_q <= hold_q ? 1'b0 : isWord(host.bhen, host.addr[0]);
      end else if (~host.memAen) begin
         hold_q <= 1'b0;
      end
   end

   // Done edge captures the hold; the odd byte is forced until the second
   // cycle's done edge, or until the host lets go of the address enable
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         forceOdd_q <= dpr_pkg::RST_BIT;
      end else if (doneRise & hostGrant_q) begin
         forceOdd_q <= hold_q;
      end else if (~host.memAen) begin
         forceOdd_q <= 1'b0;
      end
   end

   // Done edge registers the ack enable; ack only without a hold
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hostMemAck  <= dpr_pkg::RST_BIT;
      end else if (doneRise) begin
         hostMemAck  <= ~hostAckEnable;
      end else if (~host.memAen) begin
         hostMemAck  <= 1'b0;
      end
   end

   // Host lockout of the processor
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lockout_q <= dpr_pkg::RST_BIT;
      end else begin
         lockout_q <= (hostReq_q & hostGrant_q & procPermitLock)
                    | (lockout_q & host.busLock)
                    | (lockout_q & hostReq_q);
      end
   end

   // Processor lock follows its lock bit at every granted start
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         procLock_q <= dpr_pkg::RST_BIT;
      end else if (procStart) begin
         procLock_q <= proc.lockBit;
      end
   end

   // Start strobes and address mux, registered for clean outputs
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ramReadStart  <= dpr_pkg::RST_BIT;
         ramWriteStart <= dpr_pkg::RST_BIT;
         ramAddr       <= dpr_pkg::RST_ADDR[ADDR_W-1:0];
      end else begin
         ramReadStart  <= (hostGrant_q & host.rdCmd)
                        | (procGrant_q & proc.rd);
         ramWriteStart <= (hostGrant_q & host.wrCmd)
                        | (procGrant_q & proc.wr);
         if (procGrant_q) begin
            ramAddr <= proc.addr[ADDR_W-1:0];
         end else begin
            ramAddr <= {host.addr[ADDR_W-1:1], ramByteSelect};
         end
      end
   end

   // Processor data buffer and its acknowledge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         procBufEn     <= dpr_pkg::RST_BIT;
         procBufToProc <= dpr_pkg::RST_BIT;
         procRamAck    <= dpr_pkg::RST_BIT;
         procDataOut   <= dpr_pkg::RST_BYTE;
      end else begin
         procBufEn     <= (procGrant_q & proc.wr & ~ctrlAck)
                        | (proc.rd & procGrant_q & ctrlAck);
         procBufToProc <= proc.rd;
         procRamAck    <= procGrant_q & ctrlAck;
         if (procGrant_q & proc.rd & ctrlAck) begin
            procDataOut <= ramRdByte;
         end
      end
   end

   // Host write lane enables
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hostWrBufLowEn  <= dpr_pkg::RST_BIT;
         hostWrBufHighEn <= dpr_pkg::RST_BIT;
      end else begin
         hostWrBufLowEn  <= host.wrCmd & hostGrant_q
                          & ~upperLane(host.bhen, ramByteSelect);
         hostWrBufHighEn <= host.wrCmd & hostGrant_q
                          & upperLane(host.bhen, ramByteSelect);
      end
   end

   // Host read latches: capture under column strobe, drive while read
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         latchLo_q        <= dpr_pkg::RST_BYTE;
         latchHi_q        <= dpr_pkg::RST_BYTE;
         hostRdLatchOutEn <= dpr_pkg::RST_BIT;
      end else begin
         if (ramColStrobe & hostGrant_q & host.rdCmd) begin
            if (upperLane(host.bhen, ramByteSelect)) begin
               latchHi_q <= ramRdByte;
            end else begin
               latchLo_q <= ramRdByte;
            end
         end
         hostRdLatchOutEn <= host.rdCmd & host.memAen;
      end
   end

   assign hostDataOut = {latchHi_q, latchLo_q};
   assign procLockOut = procLock_q;

   // Parity check at read completion; disable forces the no-error state
   always_ff @(posedge mclk) begin
      if (!rst_n || parityCheckDisable) begin
         parityErrorFlag <= dpr_pkg::RST_BIT;
      end else if (ctrlAck & ~ramCtrlAck_n & ramReadStart) begin
         parityErrorFlag <= parMiss;
      end
   end

   initial begin
      if (ADDR_W < 2 || ADDR_W > dpr_pkg::ADDR_W) begin
         $error("dpr_access_ctrl: ADDR_W out of range");
      end
   end
endmodule : dpr_access_ctrl
`default_nettype wire

// File: sim/dpr_access_ctrl_assertions.sv
/*
 Port checker for the dual-port RAM access controller.
 Bound to dpr_access_ctrl; sees only its ports, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dpr_access_ctrl_checker (
   input wire logic               mclk,               // Clock
   input wire logic               rst_n,              // Reset, low
   input wire dpr_pkg::dpr_host_t host,               // Host group
   input wire logic               parityCheckDisable, // Error hold
   input wire logic               ramCycleDone,       // Controller done
   input wire logic               hostRdLatchOutEn,   // Latch enable
   input wire logic               hostWrBufLowEn,     // Low lane
   input wire logic               hostWrBufHighEn,    // High lane
   input wire logic               hostMemAck,         // Host ack
   input wire logic               parityErrorFlag,    // Parity error
   input wire logic               ramReadStart,       // Read start
   input wire logic               ramWriteStart       // Write start
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // Reset itself is watched, so this one is never disabled
   reset_clear_a: assert property (disable iff (1'b0)
      !rst_n |=> !(hostMemAck | ramReadStart | ramWriteStart
      | parityErrorFlag)) else $error("Output set after reset");
   start_excl_a: assert property (
      !(ramReadStart && ramWriteStart)) else $error("Two starts at once");
   par_hold_a: assert property (
      parityCheckDisable |=> !parityErrorFlag) else $error("Error held");
   ack_drop_a: assert property (
      !host.memAen |=> !hostMemAck) else $error("Ack outlived enable");
   lane_excl_a: assert property (
      !(hostWrBufLowEn && hostWrBufHighEn)) else $error("Both lanes on");
   high_lane_a: assert property (
      hostWrBufHighEn |-> $past(host.bhen && host.wrCmd))
      else $error("High lane without cause");
   latch_en_a: assert property (
      ##1 hostRdLatchOutEn == $past(host.rdCmd && host.memAen))
      else $error("Latch enable wrong");
   ack_cause_a: assert property (
      $rose(hostMemAck) |-> $past(ramCycleDone) && !$past(ramCycleDone, 2))
      else $error("Ack not on done edge");
   done_ends_a: assert property (
      $rose(ramCycleDone) |-> ##[1:3] !(ramReadStart || ramWriteStart))
      else $error("Start outlived done");

   // Word write, acked read, parity enabled by the processor
   cover property (hostWrBufLowEn ##[1:40] hostWrBufHighEn);
   cover property ($rose(hostMemAck) && hostRdLatchOutEn);
   cover property (parityCheckDisable ##1 !parityCheckDisable);
endmodule : dpr_access_ctrl_checker

bind dpr_access_ctrl dpr_access_ctrl_checker dpr_access_ctrl_checker_inst (
   .mclk(mclk), .rst_n(rst_n), .host(host),
   .parityCheckDisable(parityCheckDisable), .ramCycleDone(ramCycleDone),
   .hostRdLatchOutEn(hostRdLatchOutEn), .hostWrBufLowEn(hostWrBufLowEn),
   .hostWrBufHighEn(hostWrBufHighEn), .hostMemAck(hostMemAck),
   .parityErrorFlag(parityErrorFlag), .ramReadStart(ramReadStart),
   .ramWriteStart(ramWriteStart)
);
`default_nettype wire

// File: sim/dpr_ram_ctrl_model.sv
/*
 Model of the RAM controller that answers the block's cycles.
 Assumes start strobes are registered levels from the block.
*/
`timescale 1ns/1ps
`default_nettype none
module dpr_ram_ctrl_model (
   input  wire logic        mclk,     // Clock
   input  wire logic        rst_n,    // Reset, low
   input  wire logic        rdStart,  // Read start
   input  wire logic        wrStart,  // Write start
   input  wire logic [15:0] addr,     // RAM address
   input  wire logic        slow,     // Long access
   output logic             done,     // Cycle done level
   output logic             ack_n,    // Completion, low
   output logic             colStb,   // Column strobe
   output int               nStarts,  // Cycles begun
   output logic [15:0]      cycAddr   // Address of last cycle
);
   int   cnt;
   int   lat;
   logic startQ;
   assign lat = slow ? 5 : 1;
   // Only a rising start begins a cycle, so a held one never repeats
   always_ff @(posedge mclk) begin
      startQ <= rdStart | wrStart;
      if (!rst_n) begin
         cnt <= 0;
         nStarts <= 0;
      end else if (cnt == 0 && (rdStart | wrStart) && !startQ) begin
         cnt <= 1;
         nStarts <= nStarts + 1;
         cycAddr <= addr;
      end else if (cnt != 0) begin
         cnt <= (cnt >= lat + 4) ? 0 : cnt + 1;
      end
   end
   // Completion falls before done rises; done then stands two cycles
   assign colStb = cnt > lat && cnt <= lat + 2;
   assign ack_n = cnt != lat + 2;
   assign done = cnt > lat + 2;
endmodule : dpr_ram_ctrl_model
`default_nettype wire

// File: sim/dpr_access_ctrl_tb_top.sv
/*
 Self-checking bench for the dual-port RAM access controller.
 Drives host and processor ports; a controller model answers cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module dpr_access_ctrl_tb_top;
   logic               mclk = 1'b0;
   logic               rst_n = 1'b0;
   dpr_pkg::dpr_host_t host = '0;
   dpr_pkg::dpr_proc_t proc = '0;
   logic [15:0]        hostDataIn = 16'h0000;
   logic [15:0]        hostDataOut, cycAddr, cycAddrUnused;
   logic               latchEn, loEn, hiEn, hostMemAck;
   logic               permitLock = 1'b0;
   logic               parDis = 1'b1;
   logic [7:0]         procDataIn = 8'h00;
   logic [7:0]         procDataOut;
   logic               procRamAck, procLockOut, parErr, bufEn, bufDir;
   logic               done, ack_n, colStb, rdStart, wrStart;
   logic               slow = 1'b0;
   logic               busLk = 1'b0;
   logic               loSeen, hiSeen;
   bit                 got;
   int                 nStarts;
   int                 n_mismatch = 0;
   int                 num_checks = 0;
   int                 cycles = 0;
   logic [7:0]         mem [int]; // Reference store, filled by writes
   wire logic [5:0]    busyOuts = {hostMemAck, procRamAck, procLockOut,
                                   parErr, rdStart, wrStart};

   dpr_access_ctrl dpr_access_ctrl_inst (
      .mclk(mclk), .rst_n(rst_n), .host(host), .hostDataIn(hostDataIn),
      .hostDataOut(hostDataOut), .hostRdLatchOutEn(latchEn),
      .hostWrBufLowEn(loEn), .hostWrBufHighEn(hiEn),
      .hostMemAck(hostMemAck), .proc(proc), .procPermitLock(permitLock),
      .parityCheckDisable(parDis), .procDataIn(procDataIn),
      .procDataOut(procDataOut), .procBufEn(bufEn), .procBufToProc(bufDir),
      .procRamAck(procRamAck), .procLockOut(procLockOut),
      .parityErrorFlag(parErr), .ramCycleDone(done), .ramCtrlAck_n(ack_n),
      .ramColStrobe(colStb), .ramReadStart(rdStart),
      .ramWriteStart(wrStart), .ramAddr(cycAddrUnused)
   );
   dpr_ram_ctrl_model dpr_ram_ctrl_model_inst (
      .mclk(mclk), .rst_n(rst_n), .rdStart(rdStart), .wrStart(wrStart),
      .addr(cycAddrUnused), .slow(slow), .done(done), .ack_n(ack_n),
      .colStb(colStb), .nStarts(nStarts), .cycAddr(cycAddr)
   );

   always #4 mclk = ~mclk;

   // Four-state compare, so an unknown never passes
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   // Hold reset ten cycles; nothing may stand while it is held
   task automatic do_reset();
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (10) @(posedge mclk);
      check("reset", busyOuts, 16'h0000);
      rst_n <= 1'b1;
      @(posedge mclk);
   endtask : do_reset

   // The request is taken on the rising edge of enable with a command
   task automatic host_go(bit wr, bit [15:0] a, bit bh, bit [15:0] d);
      @(posedge mclk);
      host <= '{a, bh, !wr, wr, 1'b1, busLk};
      hostDataIn <= d;
   endtask : host_go

   // Bounded wait for the ack, noting which write lanes opened
   task automatic host_wait();
      got = 1'b0;
      loSeen = 1'b0;
      hiSeen = 1'b0;
      for (int i = 0; i < 90 && !got; i++) begin
         @(posedge mclk);
         loSeen |= loEn;
         hiSeen |= hiEn;
         got = hostMemAck === 1'b1;
      end
   endtask : host_wait

   task automatic host_end();
      host <= '{host.addr, host.bhen, 1'b0, 1'b0, 1'b0, busLk};
      repeat (2) @(posedge mclk);
      check("ack drop", hostMemAck, 1'b0);
   endtask : host_end

   task automatic host_xfer(bit wr, bit [15:0] a, bit bh);
      bit [15:0]  d;
      int         s0;
      logic [7:0] b;
      d = 16'($urandom);
      s0 = nStarts;
      host_go(wr, a, bh, d);
      host_wait();
      b = bh ? hostDataOut[15:8] : hostDataOut[7:0];
      check("host ack", got, 1'b1);
      check("cycles", 16'(nStarts - s0), 16'(1 + (bh & !a[0])));
      check("last addr", cycAddr, a | bh);
      if (wr) begin
         check("lanes", {loSeen, hiSeen}, {!(bh && a[0]), bh});
         mem[a] = (bh && a[0]) ? d[15:8] : d[7:0];
         if (bh && !a[0]) mem[a + 1] = d[15:8];
      end else if (bh && !a[0]) begin
         check("word", hostDataOut, {mem[a + 1], mem[a]});
      end else begin
         check("byte", b, mem[a]);
      end
      check("parity", parErr, 1'b0);
      host_end();
   endtask : host_xfer

   task automatic proc_go(bit wr, bit [15:0] a, bit lk, bit [7:0] d);
      @(posedge mclk);
      proc <= '{a, lk, !wr, wr, 1'b1};
      procDataIn <= d;
   endtask : proc_go

   // Strobe is dropped at the edge that shows the ready pulse
   task automatic proc_wait();
      got = 1'b0;
      for (int i = 0; i < 90 && !got; i++) begin
         @(posedge mclk);
         got = procRamAck === 1'b1;
      end
      if (got) proc <= '{proc.addr, proc.lockBit, 1'b0, 1'b0, 1'b0};
      @(posedge mclk);
   endtask : proc_wait

   task automatic proc_xfer(bit wr, bit [15:0] a, bit lk);
      bit [7:0] d;
      d = 8'($urandom);
      proc_go(wr, a, lk, d);
      proc_wait();
      check("proc ack", got, 1'b1);
      check("proc addr", cycAddr, a);
      check("proc lock", procLockOut, lk);
      check("proc buf", {bufEn, bufDir}, {wr, !wr});
      if (wr) mem[a] = d;
      else check("proc data", procDataOut, mem[a]);
   endtask : proc_xfer

   // Cut a hang short; the tests need under two thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 30000) begin
         n_mismatch++;
         final_report();
      end
   end

   initial begin
      bit [15:0] a;
      void'($urandom(30));
      do_reset();
      check("par off", parErr, 1'b0);
      parDis <= 1'b0; // processor enables detection
      // Mixed traffic: every lane mode on writes and on reads
      for (int i = 0; i < 12; i++) begin
         a = 16'($urandom) & 16'hfffe;
         slow <= (i % 3 == 0);
         host_xfer(1'b1, a, 1'b1);
         host_xfer(1'b1, a | 16'(i % 2), 1'(i / 2));
         proc_xfer(1'b1, a | 16'($urandom % 2), 1'b0);
         host_xfer(1'b0, a | 16'(i / 4 % 2), 1'(i));
         proc_xfer(1'b0, a | 16'(i % 2), 1'b0);
      end
      // A processor lock keeps the host out until it is cleared
      proc_xfer(1'b1, 16'h0010, 1'b1);
      host_go(1'b0, 16'h0010, 1'b0, 16'h0000);
      host_wait();
      check("host held", got, 1'b0);
      proc_xfer(1'b0, 16'h0010, 1'b0);
      host_wait();
      check("host late", got, 1'b1);
      check("late data", hostDataOut[7:0], mem[16]);
      host_end();
      // A locked host transfer holds the processor while LOCK stays
      permitLock <= 1'b1;
      busLk = 1'b1;
      host_xfer(1'b1, 16'h0021, 1'b0);
      proc_go(1'b0, 16'h0021, 1'b0, 8'h00);
      proc_wait();
      check("proc held", got, 1'b0);
      busLk = 1'b0;
      host.busLock <= 1'b0;
      proc_wait();
      check("proc late", got, 1'b1);
      check("late byte", procDataOut, mem[33]);
      // A reset in mid-run drops a processor lock
      proc_xfer(1'b1, 16'h0030, 1'b1);
      do_reset();
      host_xfer(1'b1, 16'h0030, 1'b0);
      final_report();
   end
endmodule : dpr_access_ctrl_tb_top
`default_nettype wire
